//--- hdl/input_filter.sv
// two-flop synchroniser followed by a stability filter for one pin
// assumes an asynchronous level input and one clock
`timescale 1ns/10ps
`default_nettype none

module input_filter #(
  parameter int FILTER_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);

  logic sync1_reg;
  logic sync2_reg;
  logic [CW-1:0] cnt_reg;

  // a zero window would let every glitch through
  if (FILTER_CYCLES < 1) begin : g_bad_cycles
    $error("input_filter: FILTER_CYCLES must be at least 1");
  end

  // first flop is read only by the second
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // output follows only after the new level held for the full window
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
      level_o <= 1'b0;
    end else if (sync2_reg == level_o) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CW'(FILTER_CYCLES - 1)) begin
      cnt_reg <= '0;
      level_o <= sync2_reg;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

endmodule : input_filter

`default_nettype wire

//--- hdl/machine_trigger_io.sv
// machine trigger interface: eight filtered inputs, four outputs,
// axi4-lite register slave and a level interrupt
// assumes one clock, synchronous active-low reset, pin state from drives
`include "trig_io_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module machine_trigger_io #(
  parameter int N_PINS = 8,
  parameter int FILTER_CYCLES = `TIO_GLITCH_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // machine side pins
  input wire logic [7:0] sig_in_i,
  output logic [3:0] sig_out_o,
  // controller side
  input wire logic alarm_i,
  input wire logic [N_PINS-1:0] pin_open_i,
  input wire logic cycle_done_i,
  output logic cycle_start_o,
  output logic [7:0] event_o,
  output logic move_allow_o,
  output logic drive_hold_o,
  output logic [11:0] io_status_o,
  output logic irq_o,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // refuse pin counts outside 1 to 16; the pins register reads back 32 bits
  if (N_PINS < 1 || N_PINS > 16) begin : g_bad_pins
    $error("machine_trigger_io: N_PINS out of 1..16");
  end

  // ************************************************************
  // input conditioning
  // ************************************************************
  logic [7:0] in_lvl;
  logic [7:0] in_prev_reg;
  logic [7:0] in_rise;

  // one filter per input pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_filt
      input_filter #(
        .FILTER_CYCLES(FILTER_CYCLES)
      ) u_filt (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(sig_in_i[gi]),
        .level_o(in_lvl[gi])
      );
    end
  endgenerate

  // edges are taken from filtered levels only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) in_prev_reg <= 8'h00;
    else in_prev_reg <= in_lvl;
  end
  assign in_rise = in_lvl & ~in_prev_reg;

  wire logic motion_en = in_lvl[6];
  wire logic process_en = in_lvl[7];

  // ************************************************************
  // registers
  // ************************************************************
  logic [2:0] ctrl_reg;
  logic [14:0] map_reg;
  logic [5:0] osel_reg;
  logic [`TIO_IRQ_W-1:0] ists_reg;
  logic [`TIO_IRQ_W-1:0] imsk_reg;
  logic [`TIO_IRQ_W-1:0] irq_set;
  trig_io_pkg::cycle_state_t state_reg;

  wire logic auto_en = ctrl_reg[`TIO_CTRL_AUTO_BIT];
  wire logic drive_en = ctrl_reg[`TIO_CTRL_DRIVE_BIT];
  wire logic alarm_any = alarm_i | ctrl_reg[`TIO_CTRL_SWALM_BIT];

  // merge write data into a register under byte strobes
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    wmerge = (old_v & ~m) | (new_v & m);
  endfunction : wmerge

  // true when an offset names a register of this block
  function automatic logic ofs_hit(input logic [7:0] a);
    ofs_hit = (a == `TIO_CTRL_OFS) || (a == `TIO_MAP_OFS) ||
              (a == `TIO_OSEL_OFS) || (a == `TIO_IO_OFS) ||
              (a == `TIO_ISTS_OFS) || (a == `TIO_IMSK_OFS) ||
              (a == `TIO_PINS_OFS);
  endfunction : ofs_hit

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // address and data are latched independently, in either order
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TIO_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= ofs_hit(awaddr_reg) ? `TIO_RESP_OKAY : `TIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers; the map has room for inputs two to six only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_reg <= 3'(`TIO_CTRL_RST);
      map_reg <= 15'(`TIO_MAP_RST);
      osel_reg <= 6'(`TIO_OSEL_RST);
      imsk_reg <= '0;
    end else if (wr_fire) begin
      unique case (awaddr_reg)
        `TIO_CTRL_OFS: ctrl_reg <= 3'(wmerge({29'h0, ctrl_reg}, wdata_reg, wstrb_reg));
        `TIO_MAP_OFS: map_reg <= 15'(wmerge({17'h0, map_reg}, wdata_reg, wstrb_reg));
        `TIO_OSEL_OFS: osel_reg <= 6'(wmerge({26'h0, osel_reg}, wdata_reg, wstrb_reg));
        `TIO_IMSK_OFS: imsk_reg <= 4'(wmerge({28'h0, imsk_reg}, wdata_reg, wstrb_reg));
        default: ;
      endcase
    end
  end

  // sticky status: a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ists_reg <= '0;
    end else begin
      logic [`TIO_IRQ_W-1:0] clr;
      clr = '0;
      if (wr_fire && awaddr_reg == `TIO_ISTS_OFS && wstrb_reg[0])
        clr = wdata_reg[`TIO_IRQ_W-1:0];
      ists_reg <= (ists_reg & ~clr) | irq_set;
    end
  end

  assign irq_o = |(ists_reg & imsk_reg);

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  // read data is registered, answer one cycle after the address
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TIO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ofs_hit({s_axi_araddr[7:2], 2'b00}) ? `TIO_RESP_OKAY : `TIO_RESP_SLVERR;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `TIO_CTRL_OFS: s_axi_rdata <= {29'h0, ctrl_reg};
        `TIO_MAP_OFS: s_axi_rdata <= {17'h0, map_reg};
        `TIO_OSEL_OFS: s_axi_rdata <= {26'h0, osel_reg};
        `TIO_IO_OFS: s_axi_rdata <= {20'h0, io_status_o};
        `TIO_ISTS_OFS: s_axi_rdata <= {28'h0, ists_reg};
        `TIO_IMSK_OFS: s_axi_rdata <= {28'h0, imsk_reg};
        `TIO_PINS_OFS: s_axi_rdata <= 32'(pin_open_i);
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // cycle sequencer
  // ************************************************************
  wire logic run_ok = auto_en && process_en;
  wire logic start_ok = in_rise[0] && run_ok && state_reg == trig_io_pkg::ST_IDLE;

  // a cycle starts on input one and ends when the motion side reports done or run_ok drops
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= trig_io_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        trig_io_pkg::ST_IDLE: if (start_ok) state_reg <= trig_io_pkg::ST_RUN;
        trig_io_pkg::ST_RUN: if (cycle_done_i || !run_ok) state_reg <= trig_io_pkg::ST_IDLE;
        default: state_reg <= trig_io_pkg::ST_IDLE;
      endcase
    end
  end

  // events fire only during a cycle, from inputs two to six
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cycle_start_o <= 1'b0;
      event_o <= 8'h00;
    end else begin
      logic [7:0] ev;
      ev = 8'h00;
      for (int k = 0; k < 5; k++) begin
        if (in_rise[k+1] && state_reg == trig_io_pkg::ST_RUN)
          ev[map_reg[k*`TIO_MAP_W +: `TIO_MAP_W]] = 1'b1;
      end
      ev[0] = 1'b0; // code zero means unassigned
      cycle_start_o <= start_ok;
      event_o <= ev;
    end
  end

  assign irq_set[`TIO_IRQ_START] = start_ok;
  assign irq_set[`TIO_IRQ_ALARM] = alarm_any && !sig_out_o[0];
  assign irq_set[`TIO_IRQ_EVENT] = |event_o;
  assign irq_set[`TIO_IRQ_MLOST] = !motion_en && in_prev_reg[6];

  // ************************************************************
  // drive gating and outputs
  // ************************************************************
  // holding current does not depend on motion enable, only movement does
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      move_allow_o <= 1'b0;
      drive_hold_o <= 1'b0;
    end else begin
      move_allow_o <= drive_en && motion_en && !alarm_any;
      drive_hold_o <= drive_en;
    end
  end

  wire logic all_open = &pin_open_i;
  wire logic one_open = |pin_open_i;
  wire logic ready = state_reg == trig_io_pkg::ST_IDLE && run_ok && motion_en && !alarm_any;

  // pick the level a selectable output shows
  function automatic logic src_level(input logic [1:0] sel, input logic rdy,
                                     input logic allo, input logic oneo,
                                     input logic run);
    unique case (trig_io_pkg::out_src_t'(sel))
      trig_io_pkg::SRC_READY: src_level = rdy;
      trig_io_pkg::SRC_ALL_OPEN: src_level = allo;
      trig_io_pkg::SRC_ONE_OPEN: src_level = oneo;
      trig_io_pkg::SRC_RUNNING: src_level = run;
    endcase
  endfunction : src_level

  // output one is fixed to alarm, the rest follow their selection
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sig_out_o <= 4'h0;
    end else begin
      sig_out_o[0] <= alarm_any;
      for (int k = 0; k < 3; k++)
        sig_out_o[k+1] <= src_level(osel_reg[k*2 +: 2], ready, all_open, one_open,
                                    state_reg == trig_io_pkg::ST_RUN);
    end
  end

  // live indicator image of all twelve signals
  always_ff @(posedge clk_i) begin
    if (!resetn_i) io_status_o <= 12'h000;
    else io_status_o <= {sig_out_o, in_lvl};
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_cycle_start: assert property (start_ok |=> cycle_start_o && state_reg == trig_io_pkg::ST_RUN)
    else $error("cycle did not start on input one");
  a_event_only_run: assert property (|event_o |-> $past(state_reg) == trig_io_pkg::ST_RUN)
    else $error("event outside a running cycle");
  a_event_code: assert property (in_rise[1] && state_reg == trig_io_pkg::ST_RUN
    && map_reg[2:0] != 3'h0 |=> event_o[$past(map_reg[2:0])])
    else $error("input two did not fire its event");
  a_no_trig_78: assert property ((in_rise[6] || in_rise[7]) && !(|in_rise[5:0])
    |=> event_o == 8'h00 && !cycle_start_o)
    else $error("input seven or eight triggered");
  a_move_gate: assert property (move_allow_o |-> $past(motion_en) && $past(drive_en))
    else $error("movement without motion enable");
  a_process_gate: assert property (state_reg == trig_io_pkg::ST_RUN && !process_en
    |=> state_reg == trig_io_pkg::ST_IDLE)
    else $error("cycle ran without process enable");
  a_alarm_out: assert property (alarm_i |=> sig_out_o[0])
    else $error("alarm not reported");
  a_out_default: assert property ($past(osel_reg) == 6'h24 ##0 $past(ready, 1) |-> sig_out_o[1])
    else $error("ready default missing");
  a_all_open: assert property (osel_reg[3:2] == 2'b01 && all_open && $stable(osel_reg)
    |=> sig_out_o[2])
    else $error("all open not shown");
  a_one_open: assert property (osel_reg[5:4] == 2'b10 && !one_open && $stable(osel_reg)
    |=> !sig_out_o[3])
    else $error("one open shown with none open");
  a_status_img: assert property (##2 io_status_o == {$past(sig_out_o), $past(in_lvl)})
    else $error("status image stale");
  a_hold_idle: assert property (drive_en && !motion_en |=> drive_hold_o && !move_allow_o)
    else $error("drive not held while stationary");
  a_glitch_rej: assert property ($rose(in_lvl[0]) |-> $past(sig_in_i[0], FILTER_CYCLES + 2))
    else $error("input passed without filtering");

  c_cycle: cover property (cycle_start_o ##[1:1000] state_reg == trig_io_pkg::ST_IDLE);
  c_event: cover property (|event_o);
  c_irq: cover property ($rose(irq_o));
  c_ready: cover property (sig_out_o[1] ##1 cycle_start_o);

endmodule : machine_trigger_io

`default_nettype wire

//--- shared/trig_io_defines.svh
// register offsets, field positions, reset values and timing counts
// of the machine trigger interface; definitions only
`ifndef TRIG_IO_DEFINES_SVH
`define TRIG_IO_DEFINES_SVH

// register byte offsets
`define TIO_CTRL_OFS 8'h00
`define TIO_MAP_OFS 8'h04
`define TIO_OSEL_OFS 8'h08
`define TIO_IO_OFS 8'h0c
`define TIO_ISTS_OFS 8'h10
`define TIO_IMSK_OFS 8'h14
`define TIO_PINS_OFS 8'h18

// control register fields
`define TIO_CTRL_AUTO_BIT 0
`define TIO_CTRL_DRIVE_BIT 1
`define TIO_CTRL_SWALM_BIT 2
`define TIO_CTRL_RST 32'h0000_0000

// event map: inputs 2..6, three bits each, code 0 means no event
`define TIO_MAP_W 3
`define TIO_MAP_RST 32'h0000_0000

// output source select: outputs 2..4, two bits each
`define TIO_OSEL_W 2
`define TIO_OSEL_RST 32'h0000_0024

// interrupt status bits
`define TIO_IRQ_START 0
`define TIO_IRQ_ALARM 1
`define TIO_IRQ_EVENT 2
`define TIO_IRQ_MLOST 3
`define TIO_IRQ_W 4

// axi responses
`define TIO_RESP_OKAY 2'b00
`define TIO_RESP_SLVERR 2'b10

// glitch filter time and its cycle count, rounded up
`define TIO_CLK_NS 50
`define TIO_GLITCH_NS 1000
`define TIO_GLITCH_CYC ((`TIO_GLITCH_NS + `TIO_CLK_NS - 1) / `TIO_CLK_NS)

`endif

//--- shared/trig_io_pkg.sv
// types shared by the trigger interface modules
// assumes trig_io_defines.svh for all numeric constants
package trig_io_pkg;

  // cycle sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } cycle_state_t;

  // sources selectable for outputs two to four
  typedef enum logic [1:0] {
    SRC_READY = 2'b00,
    SRC_ALL_OPEN = 2'b01,
    SRC_ONE_OPEN = 2'b10,
    SRC_RUNNING = 2'b11
  } out_src_t;

endpackage : trig_io_pkg

//--- tb/machine_model.sv
// machine control system model driving the eight trigger inputs
// assumes the controller's four outputs and one shared clock
`timescale 1ns/10ps
`default_nettype none

module machine_model (
  // clock
  input wire logic clk_i,
  // runner at temperature and doors closed
  input wire logic warm_i,
  // controller outputs seen by the machine
  input wire logic [3:0] sig_out_i,
  // machine levels towards the controller
  output logic [7:0] sig_o
);
  // ************
  // line control
  // ************
  initial begin
    sig_o = 8'h00;
  end

  // one line changes just after an edge; motion enable needs a warm mould
  task automatic set_line(input int n, input logic v);
    @(posedge clk_i);
    if (n == 6) begin
      sig_o[6] <= v & warm_i;
    end else begin
      sig_o[n] <= v;
    end
  endtask : set_line

  // spike of one cycle, shorter than any sane glitch window
  task automatic spike(input int n);
    set_line(n, 1'b1);
    set_line(n, 1'b0);
  endtask : spike

  // the machine uses output two as its own enable before a start
  task automatic start_cycle();
    int k;
    for (k = 0; k < 100 && sig_out_i[1] !== 1'b1; k++) begin
      @(posedge clk_i);
    end
    set_line(0, 1'b1);
  endtask : start_cycle
endmodule : machine_model
`default_nettype wire

//--- tb/machine_trigger_io_bench.sv
// self-checking bench of the machine trigger interface
// assumes the design's register map and a machine model beside it
`include "trig_io_defines.svh"
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module machine_trigger_io_bench;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic [1:0] resp;
  } row_t;

  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic warm = 1'b1;
  logic [7:0] sig_in;
  logic [3:0] sig_out_o;
  logic alarm_i = 1'b0;
  logic [7:0] pin_open_i = 8'h00;
  logic cycle_done_i = 1'b0;
  logic cycle_start_o, move_allow_o, drive_hold_o, irq_o;
  logic [7:0] event_o;
  logic [11:0] io_status_o;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] rd;
  logic [7:0] ev_seen = 8'h00;
  int num_errors = 0, checked = 0, n_start = 0, k;

  // ordinary register accesses: reset values, unmapped place, event map
  row_t rows[9] = '{
    '{1'b0, `TIO_CTRL_OFS, 32'h0, `TIO_CTRL_RST, `TIO_RESP_OKAY},
    '{1'b0, `TIO_OSEL_OFS, 32'h0, `TIO_OSEL_RST, `TIO_RESP_OKAY},
    '{1'b0, `TIO_MAP_OFS, 32'h0, `TIO_MAP_RST, `TIO_RESP_OKAY},
    '{1'b0, `TIO_IMSK_OFS, 32'h0, 32'h0, `TIO_RESP_OKAY},
    '{1'b0, 8'h1c, 32'h0, 32'h0, `TIO_RESP_SLVERR},
    '{1'b1, 8'h1c, 32'hffff_ffff, 32'h0, `TIO_RESP_SLVERR},
    '{1'b1, `TIO_MAP_OFS, 32'h0000_0035, 32'h0, `TIO_RESP_OKAY},
    '{1'b0, `TIO_MAP_OFS, 32'h0, 32'h0000_0035, `TIO_RESP_OKAY},
    '{1'b1, `TIO_IO_OFS, 32'hffff_ffff, 32'h0, `TIO_RESP_OKAY}
  };

  // 20 mhz clock
  always #25 clk_i = ~clk_i;

  machine_model mdl (.clk_i(clk_i), .warm_i(warm), .sig_out_i(sig_out_o), .sig_o(sig_in));

  // short filter window keeps each settle at a handful of cycles
  machine_trigger_io #(.N_PINS(8), .FILTER_CYCLES(2)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .sig_in_i(sig_in), .sig_out_o(sig_out_o),
    .alarm_i(alarm_i), .pin_open_i(pin_open_i), .cycle_done_i(cycle_done_i),
    .cycle_start_o(cycle_start_o), .event_o(event_o), .move_allow_o(move_allow_o),
    .drive_hold_o(drive_hold_o), .io_status_o(io_status_o), .irq_o(irq_o),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  // one-cycle pulses are caught mid-cycle, away from the launching edge
  always @(negedge clk_i) begin
    if (cycle_start_o === 1'b1) n_start++;
    ev_seen <= ev_seen | event_o;
  end

  // *************
  // bus and timing
  // *************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : wait_cyc

  // ready is judged mid-cycle so the decision matches the next edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    logic ta, tw, tb;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_i);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (i == 40) num_errors++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic ta, tr;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_i);
      ta = s_axi_arvalid & s_axi_arready;
      tr = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (i == 40) num_errors++;
  endtask : axi_rd

  task automatic complete_run();
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // a hang costs a mismatch and ends the run the normal way
  initial begin
    #(50 * 6000);
    num_errors++;
    complete_run();
  end

  // ***********
  // main course
  // ***********
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].a, rows[i].d, resp);
      end else begin
        axi_rd(rows[i].a, rd, resp);
        `CHK(rd, rows[i].rd)
      end
      `CHK(resp, rows[i].resp)
    end
    // alarm reaches output one; masked status leaves irq low
    @(posedge clk_i);
    alarm_i <= 1'b1;
    wait_cyc(3);
    `CHK(sig_out_o[0], 1'b1)
    @(posedge clk_i);
    alarm_i <= 1'b0;
    wait_cyc(3);
    `CHK(sig_out_o[0], 1'b0)
    `CHK(irq_o, 1'b0)
    // enables, holding current and the ready indication
    axi_wr(`TIO_CTRL_OFS, 32'h0000_0003, resp);
    mdl.set_line(6, 1'b1);
    mdl.set_line(7, 1'b1);
    wait_cyc(8);
    `CHK(io_status_o[7:0], 8'hc0)
    `CHK(move_allow_o, 1'b1)
    `CHK(drive_hold_o, 1'b1)
    `CHK(sig_out_o[1], 1'b1)
    // pin position outputs with their default sources
    @(posedge clk_i);
    pin_open_i <= 8'h10;
    wait_cyc(3);
    `CHK(sig_out_o[3:2], 2'b10)
    @(posedge clk_i);
    pin_open_i <= 8'hff;
    wait_cyc(3);
    `CHK(sig_out_o[3:2], 2'b11)
    `CHK(io_status_o[11:8], 4'he)
    // a spike and a start without process enable are both refused
    mdl.spike(0);
    wait_cyc(8);
    `CHK(n_start, 0)
    mdl.set_line(7, 1'b0);
    wait_cyc(8);
    mdl.set_line(0, 1'b1);
    wait_cyc(8);
    `CHK(n_start, 0)
    mdl.set_line(0, 1'b0);
    mdl.set_line(7, 1'b1);
    wait_cyc(8);
    // a real start, then events from inputs two and three
    axi_wr(`TIO_IMSK_OFS, 32'h0000_0001, resp);
    mdl.start_cycle();
    for (k = 0; k < 40 && n_start == 0; k++) wait_cyc(1);
    wait_cyc(2);
    `CHK(n_start, 1)
    `CHK(irq_o, 1'b1)
    `CHK(sig_out_o[1], 1'b0)
    mdl.set_line(1, 1'b1);
    mdl.set_line(2, 1'b1);
    wait_cyc(8);
    `CHK(ev_seen, 8'h60)
    // motion enable lost and back: blocks movement, never an event
    mdl.set_line(6, 1'b0);
    wait_cyc(8);
    `CHK(move_allow_o, 1'b0)
    `CHK(drive_hold_o, 1'b1)
    mdl.set_line(6, 1'b1);
    wait_cyc(8);
    `CHK(ev_seen, 8'h60)
    axi_rd(`TIO_ISTS_OFS, rd, resp);
    `CHK(rd[3:0], 4'hf)
    axi_wr(`TIO_ISTS_OFS, 32'h0000_000f, resp);
    wait_cyc(2);
    `CHK(irq_o, 1'b0)
    // output two switched to the running source, then the cycle ends
    axi_wr(`TIO_OSEL_OFS, 32'h0000_0027, resp);
    wait_cyc(3);
    `CHK(sig_out_o[1], 1'b1)
    @(posedge clk_i);
    cycle_done_i <= 1'b1;
    @(posedge clk_i);
    cycle_done_i <= 1'b0;
    wait_cyc(4);
    `CHK(sig_out_o[1], 1'b0)
    axi_wr(`TIO_OSEL_OFS, 32'h0000_0024, resp);
    wait_cyc(3);
    `CHK(sig_out_o[1], 1'b1)
    // a second cycle, cut short by dropping process enable
    mdl.set_line(0, 1'b0);
    wait_cyc(8);
    mdl.start_cycle();
    wait_cyc(8);
    `CHK(n_start, 2)
    axi_wr(`TIO_OSEL_OFS, 32'h0000_0027, resp);
    wait_cyc(3);
    `CHK(sig_out_o[1], 1'b1)
    mdl.set_line(7, 1'b0);
    wait_cyc(8);
    `CHK(sig_out_o[1], 1'b0)
    // software alarm shows on output one and blocks movement
    axi_wr(`TIO_CTRL_OFS, 32'h0000_0007, resp);
    wait_cyc(3);
    `CHK(sig_out_o[0], 1'b1)
    `CHK(move_allow_o, 1'b0)
    complete_run();
  end
endmodule : machine_trigger_io_bench
`default_nettype wire
